// ===== design/ppu_pin_sync.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`default_nettype none
module ppu_pin_sync
  import ppu_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic level_d;

  assign level_d = (s2_q == s3_q) ? s3_q : level_q;
  assign level_out = level_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_q <= PPU_SYNC_RST;
      s2_q <= PPU_SYNC_RST;
      s3_q <= PPU_SYNC_RST;
      level_q <= PPU_SYNC_RST;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end
endmodule
`default_nettype wire

// ===== design/ppu_pkg.sv
// constants and types for the per-pin input pull-up control of one 8-bit port
`default_nettype none
package ppu_pkg;
  localparam int PPU_PINS = 8;
  localparam int PPU_MODE_W = 2;
  localparam logic [1:0] PPU_MODE_1 = 2'h1;
  localparam logic [1:0] PPU_MODE_2 = 2'h2;
  localparam logic [1:0] PPU_MODE_3 = 2'h3;
  localparam logic [7:0] PPU_PULL_RST = 8'h00;
  localparam logic PPU_SYNC_RST = 1'b1;
  localparam int PPU_SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    PPU_RUN = 2'b00,
    PPU_SWSTBY = 2'b01,
    PPU_HWSTBY = 2'b10
  } ppu_state_t;
endpackage
`default_nettype wire

// ===== design/ppu_pullup_ctrl.sv
// per-pin input pull-up control for one 8-bit general-purpose port
`default_nettype none
module ppu_pullup_ctrl (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ppu_pkg::PPU_MODE_W-1:0] chip_mode,
  input wire logic external_expansion_enable,
  input wire logic area_bus_width_select,
  input wire logic [ppu_pkg::PPU_PINS-1:0] port_direction_bits,
  input wire logic [ppu_pkg::PPU_PINS-1:0] port_output_latch_bits,
  input wire logic [ppu_pkg::PPU_PINS-1:0] periph_output_owned,
  input wire logic sw_standby,
  input wire logic hw_standby_n,
  output logic [ppu_pkg::PPU_PINS-1:0] pull_up_en,
  output logic pull_up_allowed,
  output logic [1:0] power_state
);
  import ppu_pkg::*;

  // ==========================================================
  // mode qualification
  logic mode_expanded;
  logic mode_single;
  logic mode_allowed;

  assign mode_expanded = (chip_mode == PPU_MODE_1) || (chip_mode == PPU_MODE_2) ||
                         (chip_mode == PPU_MODE_3);
  assign mode_single = (chip_mode == PPU_MODE_2) || (chip_mode == PPU_MODE_3);
  // narrow bus in expanded modes with external_expansion_enable high leaves mode_allowed low, so all pull-ups stay off
  assign mode_allowed = (mode_expanded && external_expansion_enable &&
                         area_bus_width_select) ||
                        (mode_single && !external_expansion_enable);
  assign pull_up_allowed = mode_allowed;

  // ==========================================================
  // hardware standby pin, crossed into mclk
  logic hw_standby_n_sync;

  ppu_pin_sync u_hwstby_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(hw_standby_n),
    .level_out(hw_standby_n_sync)
  );

  // ==========================================================
  // power state
  ppu_state_t state_q;
  ppu_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PPU_RUN: begin
        if (!hw_standby_n_sync) begin
          state_d = PPU_HWSTBY;
        end else if (sw_standby) begin
          state_d = PPU_SWSTBY;
        end
      end
      PPU_SWSTBY: begin
        if (!hw_standby_n_sync) begin
          state_d = PPU_HWSTBY;
        end else if (!sw_standby) begin
          state_d = PPU_RUN;
        end
      end
      PPU_HWSTBY: begin
        if (hw_standby_n_sync) begin
          state_d = PPU_RUN;
        end
      end
      default: begin
        state_d = PPU_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= PPU_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  assign power_state = state_q;

  // ==========================================================
  // per-pin live enable and standby hold
  logic [PPU_PINS-1:0] live_en;
  logic [PPU_PINS-1:0] hold_q;
  logic [PPU_PINS-1:0] hold_d;
  logic [PPU_PINS-1:0] pull_sel;
  logic in_run;
  logic in_swstby;

  assign in_run = (state_q == PPU_RUN);
  assign in_swstby = (state_q == PPU_SWSTBY);

  genvar gi;
  generate
    for (gi = 0; gi < PPU_PINS; gi = gi + 1) begin : g_pin
      // in an allowed mode, input direction with latch at 1 pulls up, unless a peripheral drives the pin
      assign live_en[gi] = mode_allowed && !port_direction_bits[gi] &&
                           port_output_latch_bits[gi] &&
                           !periph_output_owned[gi];
      // while running the hold tracks the live value, so entry freezes the last one
      assign hold_d[gi] = in_run ? live_en[gi] : hold_q[gi];
      assign pull_sel[gi] = in_swstby ? (hold_q[gi] && mode_allowed &&
                                         !periph_output_owned[gi]) :
                            in_run ? live_en[gi] : 1'b0;
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hold_q <= PPU_PULL_RST;
    end else begin
      hold_q <= hold_d;
    end
  end

  // combinational so the enable moves in the same cycle as its inputs
  assign pull_up_en = sys_rst ? PPU_PULL_RST : pull_sel;

  // ==========================================================
  // checks
  chk_reset_all_off: assert property (@(posedge mclk)
      sys_rst |-> pull_up_en == PPU_PULL_RST)
    else $error("pull-up on during reset");

  chk_reset_state: assert property (@(posedge mclk)
      sys_rst |=> (state_q == PPU_RUN && hold_q == PPU_PULL_RST))
    else $error("state or hold not cleared by reset");

  chk_hwstby_all_off: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == PPU_HWSTBY) |-> pull_up_en == PPU_PULL_RST)
    else $error("pull-up on during hardware standby");

  chk_barred_mode_off: assert property (@(posedge mclk) disable iff (sys_rst)
      (mode_expanded && external_expansion_enable && !area_bus_width_select)
      |-> pull_up_en == PPU_PULL_RST)
    else $error("pull-up on in narrow expanded mode");

  chk_swstby_mode_off: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == PPU_SWSTBY && !mode_allowed) |-> pull_up_en == PPU_PULL_RST)
    else $error("pull-up on in software standby outside allowed modes");

  chk_run_pin_follow: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == PPU_RUN && mode_allowed) |->
      pull_up_en == (~port_direction_bits & port_output_latch_bits &
                     ~periph_output_owned))
    else $error("pull-up does not follow direction and latch");

  chk_run_combo_off: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == PPU_RUN) |->
      (pull_up_en & (port_direction_bits | ~port_output_latch_bits)) == PPU_PULL_RST)
    else $error("pull-up on for output direction or cleared latch");

  chk_periph_forces_off: assert property (@(posedge mclk) disable iff (sys_rst)
      (periph_output_owned & pull_up_en) == PPU_PULL_RST)
    else $error("pull-up on for peripheral output pin");

  chk_live_same_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == PPU_RUN && !mode_allowed) |-> pull_up_en == PPU_PULL_RST)
    else $error("pull-up on outside allowed modes");

  // ==========================================================
  // power state, standby hold and synchroniser checks
  chk_hwstby_entry_time: assert property (@(posedge mclk) disable iff (sys_rst)
      (!hw_standby_n) [*6] |-> state_q == PPU_HWSTBY)
    else $error("hardware standby not reached in time");

  chk_hwstby_exit_time: assert property (@(posedge mclk) disable iff (sys_rst)
      hw_standby_n [*6] |-> state_q != PPU_HWSTBY)
    else $error("hardware standby not left in time");

  chk_hwstby_wins: assert property (@(posedge mclk) disable iff (sys_rst)
      !hw_standby_n_sync |=> state_q == PPU_HWSTBY)
    else $error("hardware standby not entered from synchronised pin");

  // a synchronised change needs the pin steady on the two edges that fed stages two and three
  chk_sync_agree: assert property (@(posedge mclk) disable iff (sys_rst)
      ($changed(hw_standby_n_sync) && !$past(sys_rst)) |->
      (hw_standby_n_sync == $past(hw_standby_n, 3) &&
       hw_standby_n_sync == $past(hw_standby_n, 4)))
    else $error("standby pin change accepted without agreement");

  chk_swstby_entry: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == PPU_RUN && hw_standby_n_sync && sw_standby) |=> state_q == PPU_SWSTBY)
    else $error("software standby not entered");

  chk_swstby_exit: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == PPU_SWSTBY && hw_standby_n_sync && !sw_standby) |=> state_q == PPU_RUN)
    else $error("software standby not left");

  chk_hold_frozen: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q != PPU_RUN) |=> $stable(hold_q))
    else $error("standby hold moved outside run");

  chk_swstby_entry_keep: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == PPU_RUN && hw_standby_n_sync && sw_standby &&
       $stable(periph_output_owned) && $stable(chip_mode) &&
       $stable(external_expansion_enable) && $stable(area_bus_width_select))
      ##1 (state_q == PPU_SWSTBY && $stable(periph_output_owned) && $stable(chip_mode) &&
           $stable(external_expansion_enable) && $stable(area_bus_width_select))
      |-> pull_up_en == $past(pull_up_en))
    else $error("pull-up changed on software standby entry");

  chk_swstby_steady: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == PPU_SWSTBY && $past(state_q) == PPU_SWSTBY &&
       $stable(port_direction_bits) == 1'b0 && $stable(periph_output_owned) &&
       $stable(chip_mode) && $stable(external_expansion_enable) &&
       $stable(area_bus_width_select))
      |-> $stable(pull_up_en))
    else $error("pull-up moved with direction bits in software standby");
endmodule
`default_nettype wire

// ===== verif/tb_ppu_pullup_ctrl.sv
// self-checking bench for the per-pin pull-up control
`default_nettype none
module tb_ppu_pullup_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import ppu_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] chip_mode = 2'h0;
  logic ext_exp = 1'b0;
  logic bus_wide = 1'b0;
  logic [7:0] dir = 8'h00;
  logic [7:0] lat = 8'h00;
  logic [7:0] own = 8'h00;
  logic sw = 1'b0;
  logic hw_n = 1'b1;
  logic [7:0] pu;
  logic allowed;
  logic [1:0] pstate;
  int miscompares = 0;
  int cmp_count = 0;
  logic [8:0] exp_q[$];

  ppu_pullup_ctrl dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .chip_mode(chip_mode),
    .external_expansion_enable(ext_exp), .area_bus_width_select(bus_wide),
    .port_direction_bits(dir), .port_output_latch_bits(lat),
    .periph_output_owned(own), .sw_standby(sw), .hw_standby_n(hw_n),
    .pull_up_en(pu), .pull_up_allowed(allowed), .power_state(pstate)
  );

  always #5 mclk = ~mclk;

  // expected {allowed, pull-ups} in run state
  function logic [8:0] model();
    logic al;
    al = (chip_mode != 2'h0) &&
         ((ext_exp && bus_wide) || (!ext_exp && chip_mode >= PPU_MODE_2));
    return {al, al ? (~dir & lat & ~own) : 8'h00};
  endfunction

  task automatic chk(string what, logic [8:0] e, logic [8:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", what, e, s);
    end
  endtask

  task summarize();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task wait_ps(logic [1:0] v);
    for (int n = 0; n < 20; n++) begin
      @(posedge mclk);
      #1;
      if (pstate === v) return;
    end
    miscompares++;
    summarize();
  endtask

  // outputs are combinational: compare shortly before the edge, once they have settled
  always begin
    @(negedge mclk);
    #4;
    if (exp_q.size() > 0) begin
      chk("pull_up", exp_q.pop_front(), {allowed, pu});
    end
  end

  initial begin
    void'($urandom(44306));
    repeat (12) @(posedge mclk);
    @(negedge mclk) sys_rst = 1'b0;
    for (int k = 0; k < 16; k++) begin
      @(negedge mclk);
      {chip_mode, ext_exp, bus_wide} = k[3:0];
      dir = 8'h00;
      lat = 8'hFF;
      own = 8'h5A;
      exp_q.push_back(model());
    end
    repeat (300) begin
      @(negedge mclk);
      {chip_mode, ext_exp, bus_wide} = 4'($urandom);
      dir = 8'($urandom);
      lat = 8'($urandom);
      own = ($urandom_range(2) == 0) ? 8'($urandom) : 8'h00;
      exp_q.push_back(model());
    end
    @(negedge mclk);
    chip_mode = PPU_MODE_2;
    ext_exp = 1'b0;
    dir = 8'h30;
    lat = 8'hF0;
    own = 8'h00;
    exp_q.push_back(model());
    @(negedge mclk);
    sw = 1'b1;
    exp_q.push_back(model());
    @(negedge mclk);
    dir = 8'hFF;
    lat = 8'h00;
    exp_q.push_back({1'b1, 8'hC0});
    chk("state", 9'(PPU_SWSTBY), 9'(pstate));
    @(negedge mclk);
    dir = 8'h00;
    lat = 8'hFF;
    exp_q.push_back({1'b1, 8'hC0});
    @(negedge mclk);
    own = 8'h40;
    exp_q.push_back({1'b1, 8'h80});
    @(negedge mclk);
    ext_exp = 1'b1;
    bus_wide = 1'b0;
    exp_q.push_back({1'b0, 8'h00});
    @(negedge mclk);
    sw = 1'b0;
    bus_wide = 1'b1;
    own = 8'h00;
    dir = 8'h00;
    lat = 8'hFF;
    wait_ps(PPU_RUN);
    @(negedge mclk);
    hw_n = 1'b0;
    exp_q.push_back(model());
    wait_ps(PPU_HWSTBY);
    @(negedge mclk);
    exp_q.push_back({1'b1, 8'h00});
    hw_n = 1'b1;
    wait_ps(PPU_RUN);
    @(negedge mclk);
    sys_rst = 1'b1;
    exp_q.push_back({1'b1, 8'h00});
    @(negedge mclk);
    sys_rst = 1'b0;
    exp_q.push_back(model());
    repeat (2) @(posedge mclk);
    summarize();
  end
endmodule
`default_nettype wire
